// >>> verilog/lcoc_output_ctrl.sv
// Output control state machine of the light curtain receiver.
//
// How it works
// - After power-on the block waits for self-test and configuration before any scanning.
// - A fault found at power-up stops scanning, keeps both outputs off and flags diagnostics.
// - A passed self-test leads straight into alignment, which looks for the emitter sync.
// - With automatic restart, alignment with sync and clear beams enters run without reset.
// - With latching, all beams aligned after power-up double-flashes reset with outputs off.
// - With latching, run is entered only after a valid manual reset following alignment.
// - In run any blocked beam switches both outputs off at the next clock edge.
// - With automatic restart, clear beams after a trip turn the outputs back on alone.
// - With latching, clear beams after a trip show all zones green and single-flash reset.
// - With latching, outputs come back only on a valid reset while all beams are clear.
// - A fault in run stops scanning, forces outputs off, flags diagnostics and locks out.
// - When beam 1 is blocked the other zone indicators are off as unevaluated.
`timescale 1ns/10ps
module lcoc_output_ctrl
  import lcoc_pkg::*;
#(
  parameter int DEB_CYC = DEBOUNCE_CYC,
  parameter int MIN_CYC = RESET_MIN_CYC,
  parameter int MAX_CYC = RESET_MAX_CYC,
  parameter int HALF_CYC = FLASH_HALF_CYC
) (
  input wire logic mclk_in,
  input wire logic nrst_in,
  input wire logic selftest_done_in,
  input wire logic selftest_fault_in,
  input wire logic latch_mode_in,
  input wire logic fault_in,
  input wire lcoc_scan_s scan_in,
  input wire logic reset_switch_in,
  output logic scan_enable_out,
  output logic [1:0] safety_switching_output_out,
  output lcoc_ind_s ind_out,
  output lcoc_state_e state_out
);

  localparam int FW = $clog2(HALF_CYC + 1);

  lcoc_state_e state_r, state_nxt;
  logic mode_r, mode_nxt;
  logic out_r, out_nxt;
  logic scan_r, scan_nxt;
  lcoc_ind_s ind_r, ind_nxt;
  logic [FW-1:0] fcnt_r, fcnt_nxt;
  logic [2:0] slot_r, slot_nxt;
  logic valid_reset;
  logic all_clear;

  // ----------------------------------------------------------------
  // Reset switch qualification.
  // ----------------------------------------------------------------
  lcoc_reset_filter #(
    .DEB_CYC(DEB_CYC),
    .MIN_CYC(MIN_CYC),
    .MAX_CYC(MAX_CYC)
  ) u_reset_filter (
    .mclk_in(mclk_in),
    .nrst_in(nrst_in),
    .switch_closed_in(reset_switch_in),
    .valid_reset_out(valid_reset)
  );

  // Beams count as clear only with sync present and nothing blocked.
  assign all_clear = scan_in.sync_ok && !scan_in.any_blocked && !scan_in.beam1_blocked;

  // Picks one slot of a flash pattern.
  function automatic logic flash_bit(input logic [7:0] pat, input logic [2:0] slot);
    flash_bit = pat[slot];
  endfunction : flash_bit

  // ----------------------------------------------------------------
  // Flash timebase.
  // ----------------------------------------------------------------
  always_comb begin
    fcnt_nxt = fcnt_r + FW'(1);
    slot_nxt = slot_r;
    if (fcnt_r >= FW'(HALF_CYC - 1)) begin
      fcnt_nxt = '0;
      slot_nxt = slot_r + 3'h1;
    end
  end

  always_ff @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      fcnt_r <= '0;
      slot_r <= '0;
    end else begin
      fcnt_r <= fcnt_nxt;
      slot_r <= slot_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Main state machine next values.
  // ----------------------------------------------------------------
  always_comb begin
    state_nxt = state_r;
    mode_nxt = mode_r;
    case (state_r)
      ST_SELFTEST: begin
        // Configuration is captured while self-test runs.
        mode_nxt = latch_mode_in;
        if (selftest_done_in) begin
          if (selftest_fault_in) begin
            state_nxt = ST_LOCKOUT;
          end else begin
            state_nxt = ST_ALIGN;
          end
        end
      end
      ST_ALIGN: begin
        if (all_clear) begin
          state_nxt = mode_r ? ST_WAIT_RESET : ST_RUN;
        end
      end
      ST_WAIT_RESET: begin
        if (!all_clear) begin
          state_nxt = ST_ALIGN;
        end else if (valid_reset) begin
          state_nxt = ST_RUN;
        end
      end
      ST_RUN: begin
        if (!all_clear) begin
          state_nxt = ST_LATCHED;
        end
      end
      ST_LATCHED: begin
        if (all_clear) begin
          if (!mode_r) begin
            state_nxt = ST_RUN;
          end else if (valid_reset) begin
            state_nxt = ST_RUN;
          end
        end
      end
      ST_LOCKOUT: begin
        state_nxt = ST_LOCKOUT;
      end
      default: begin
        state_nxt = ST_LOCKOUT;
      end
    endcase
    // A fault outside self-test locks out from any state.
    if (fault_in && state_r != ST_SELFTEST) begin
      state_nxt = ST_LOCKOUT;
    end
  end

  // ----------------------------------------------------------------
  // Output and indicator next values, taken from the next state.
  // ----------------------------------------------------------------
  always_comb begin
    out_nxt = 1'b0;
    scan_nxt = 1'b0;
    ind_nxt = '0;
    case (state_nxt)
      ST_SELFTEST: begin
        scan_nxt = 1'b0;
      end
      ST_ALIGN: begin
        scan_nxt = 1'b1;
      end
      ST_WAIT_RESET: begin
        scan_nxt = 1'b1;
        ind_nxt.reset_led = flash_bit(PAT_DOUBLE, slot_nxt);
      end
      ST_RUN: begin
        scan_nxt = 1'b1;
        out_nxt = 1'b1;
        ind_nxt.reset_led = 1'b1;
      end
      ST_LATCHED: begin
        scan_nxt = 1'b1;
        if (mode_r && all_clear) begin
          ind_nxt.reset_led = flash_bit(PAT_SINGLE, slot_nxt);
        end else begin
          ind_nxt.reset_led = 1'b1;
        end
      end
      ST_LOCKOUT: begin
        ind_nxt.diag_fault = 1'b1;
      end
      default: begin
        ind_nxt.diag_fault = 1'b1;
      end
    endcase
    // Zone indicators follow the scan while scanning.
    if (scan_nxt) begin
      ind_nxt.zone_red = scan_in.zone_blocked;
      ind_nxt.zone_green = ~scan_in.zone_blocked;
      if (scan_in.beam1_blocked) begin
        ind_nxt.zone_red = 8'h01;
        ind_nxt.zone_green = 8'h00;
      end
    end
  end

  // ----------------------------------------------------------------
  // State registers.
  // ----------------------------------------------------------------
  always_ff @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      state_r <= ST_SELFTEST;
      mode_r <= 1'b0;
      out_r <= 1'b0;
      scan_r <= 1'b0;
      ind_r <= '0;
    end else begin
      state_r <= state_nxt;
      mode_r <= mode_nxt;
      out_r <= out_nxt;
      scan_r <= scan_nxt;
      ind_r <= ind_nxt;
    end
  end

  // Both channels come from the same flop and are never on outside run.
  assign safety_switching_output_out = {out_r, out_r};
  assign scan_enable_out = scan_r;
  assign ind_out = ind_r;
  assign state_out = state_r;

endmodule : lcoc_output_ctrl

// >>> verilog/lcoc_pkg.sv
// Package with states, structs and timing constants for the light curtain output control.
package lcoc_pkg;

  // ----------------------------------------------------------------
  // Timing.
  // ----------------------------------------------------------------
  localparam int CLK_HZ = 10000000;
  localparam int RESET_MIN_MS = 250;
  localparam int RESET_MAX_MS = 2000;
  localparam int RESET_MIN_CYC = (CLK_HZ / 1000) * RESET_MIN_MS;
  localparam int RESET_MAX_CYC = (CLK_HZ / 1000) * RESET_MAX_MS;
  localparam int DEBOUNCE_US = 10000;
  localparam int DEBOUNCE_CYC = (CLK_HZ / 1000000) * DEBOUNCE_US;
  localparam int FLASH_HALF_MS = 125;
  localparam int FLASH_HALF_CYC = (CLK_HZ / 1000) * FLASH_HALF_MS;
  localparam int FLASH_SLOTS = 8;
  localparam int NUM_ZONES = 8;

  // Reset indicator flash patterns over eight slots of the flash frame.
  localparam logic [7:0] PAT_SINGLE = 8'hF0;
  localparam logic [7:0] PAT_DOUBLE = 8'hA0;

  // ----------------------------------------------------------------
  // Types.
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_SELFTEST,
    ST_ALIGN,
    ST_WAIT_RESET,
    ST_RUN,
    ST_LATCHED,
    ST_LOCKOUT
  } lcoc_state_e;

  // Scan side view of the beams.
  typedef struct packed {
    logic sync_ok;
    logic beam1_blocked;
    logic any_blocked;
    logic [7:0] zone_blocked;
  } lcoc_scan_s;

  // Indicator outputs.
  typedef struct packed {
    logic reset_led;
    logic [7:0] zone_green;
    logic [7:0] zone_red;
    logic diag_fault;
  } lcoc_ind_s;

endpackage : lcoc_pkg

// >>> verilog/lcoc_reset_filter.sv
// Synchroniser, debounce and pulse width check for the operator reset switch.
`timescale 1ns/10ps
module lcoc_reset_filter
  import lcoc_pkg::*;
#(
  parameter int DEB_CYC = DEBOUNCE_CYC,
  parameter int MIN_CYC = RESET_MIN_CYC,
  parameter int MAX_CYC = RESET_MAX_CYC
) (
  input wire logic mclk_in,
  input wire logic nrst_in,
  input wire logic switch_closed_in,
  output logic valid_reset_out
);

  localparam int CW = $clog2(MAX_CYC + 2);
  localparam int DW = $clog2(DEB_CYC + 2);

  logic sync1_r, sync2_r;
  logic stable_r, stable_nxt;
  logic [DW-1:0] deb_r, deb_nxt;
  logic [CW-1:0] hold_r, hold_nxt;
  logic valid_r, valid_nxt;

  // ----------------------------------------------------------------
  // Next state: debounce then time the closed period.
  // ----------------------------------------------------------------
  always_comb begin
    stable_nxt = stable_r;
    deb_nxt = deb_r;
    hold_nxt = hold_r;
    valid_nxt = 1'b0;
    // The level must hold for the debounce time before it is believed.
    if (sync2_r == stable_r) begin
      deb_nxt = '0;
    end else if (deb_r >= DW'(DEB_CYC - 1)) begin
      deb_nxt = '0;
      stable_nxt = sync2_r;
    end else begin
      deb_nxt = deb_r + DW'(1);
    end
    // Count the closed time; a release in the window gives one pulse.
    if (stable_r) begin
      if (hold_r <= CW'(MAX_CYC)) begin
        hold_nxt = hold_r + CW'(1);
      end
    end else begin
      hold_nxt = '0;
    end
    if (stable_r && !stable_nxt) begin
      valid_nxt = (hold_r >= CW'(MIN_CYC)) && (hold_r <= CW'(MAX_CYC));
    end
  end

  // Registers; the first synchroniser stage feeds only the second.
  always_ff @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      sync1_r <= 1'b0;
      sync2_r <= 1'b0;
      stable_r <= 1'b0;
      deb_r <= '0;
      hold_r <= '0;
      valid_r <= 1'b0;
    end else begin
      sync1_r <= switch_closed_in;
      sync2_r <= sync1_r;
      stable_r <= stable_nxt;
      deb_r <= deb_nxt;
      hold_r <= hold_nxt;
      valid_r <= valid_nxt;
    end
  end

  assign valid_reset_out = valid_r;

endmodule : lcoc_reset_filter

// >>> testbench/lcoc_operator.sv
// Operator reset switch model for the light curtain output control bench.
`timescale 1ns/10ps
module lcoc_operator (
  input wire logic mclk_in,
  input wire logic press_in,
  input wire logic [7:0] len_in,
  output logic busy_out,
  output logic switch_out
);
  int cnt = 0;
  // Holds the switch closed for the asked span, then bounces once while opening.
  always @(posedge mclk_in) begin
    if (press_in && cnt == 0) cnt <= len_in + 3;
    else if (cnt != 0) cnt <= cnt - 1;
  end
  assign busy_out = (cnt != 0);
  assign switch_out = (cnt > 3) || (cnt == 2);
endmodule : lcoc_operator

// >>> testbench/lcoc_output_ctrl_monitor.sv
// Checker of the output control state machine, bound to its ports.
`timescale 1ns/10ps
module lcoc_output_ctrl_monitor
  import lcoc_pkg::*;
(
  input wire logic mclk_in,
  input wire logic nrst_in,
  input wire logic selftest_done_in,
  input wire logic selftest_fault_in,
  input wire logic latch_mode_in,
  input wire logic fault_in,
  input wire lcoc_scan_s scan_in,
  input wire logic reset_switch_in,
  input wire logic scan_enable_out,
  input wire logic [1:0] safety_switching_output_out,
  input wire lcoc_ind_s ind_out,
  input wire lcoc_state_e state_out
);
  // ----------------------------------------------------------------
  // Properties.
  // ----------------------------------------------------------------
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!nrst_in);
  wire logic clr = scan_in.sync_ok && !scan_in.any_blocked && !scan_in.beam1_blocked;
  sequence s_trip;
    state_out == ST_RUN && scan_in.any_blocked;
  endsequence
  sequence s_off;
    safety_switching_output_out == 2'h0;
  endsequence
  idle_quiet_a: assert property (state_out == ST_SELFTEST |-> !scan_enable_out ##0 s_off)
    else $error("scanning or outputs on during self-test");
  boot_fault_a: assert property (
    state_out == ST_SELFTEST && selftest_done_in
    && selftest_fault_in |=> state_out == ST_LOCKOUT && !scan_enable_out)
    else $error("power-up fault did not lock out");
  boot_pass_a: assert property (
    state_out == ST_SELFTEST && selftest_done_in && !fault_in
    && !selftest_fault_in |=> state_out == ST_ALIGN && scan_enable_out)
    else $error("passed self-test did not enter alignment");
  auto_run_a: assert property (
    (state_out inside {ST_ALIGN, ST_LATCHED}) && !latch_mode_in
    && clr && !fault_in |=> state_out == ST_RUN)
    else $error("auto restart did not enter run");
  latch_wait_a: assert property (latch_mode_in && state_out == ST_ALIGN |=> s_off)
    else $error("latching start switched outputs on");
  trip_off_a: assert property (s_trip |=> s_off)
    else $error("blocked beam left outputs on");
  latch_hold_a: assert property (
    latch_mode_in && state_out == ST_LATCHED && !clr
    |=> state_out != ST_RUN)
    else $error("latch left while beams blocked");
  fault_lock_a: assert property (
    fault_in && state_out != ST_SELFTEST
    |=> state_out == ST_LOCKOUT && ind_out.diag_fault ##0 s_off)
    else $error("run fault did not lock out");
  lock_stay_a: assert property (
    state_out == ST_LOCKOUT |=> state_out == ST_LOCKOUT
    && !scan_enable_out)
    else $error("lockout was left without power cycle");
  beam_one_a: assert property (
    scan_in.beam1_blocked |=> ind_out.zone_green == 8'h00
    && ind_out.zone_red[7:1] == 7'h00)
    else $error("zones lit while beam one blocked");
  out_pair_a: assert property (
    safety_switching_output_out != 2'h0
    |-> safety_switching_output_out == 2'h3 && state_out == ST_RUN)
    else $error("outputs on outside run or unequal");
endmodule : lcoc_output_ctrl_monitor
bind lcoc_output_ctrl lcoc_output_ctrl_monitor u_mon (.mclk_in(mclk_in), .nrst_in(nrst_in),
  .selftest_done_in(selftest_done_in), .selftest_fault_in(selftest_fault_in),
  .latch_mode_in(latch_mode_in), .fault_in(fault_in), .scan_in(scan_in),
  .reset_switch_in(reset_switch_in), .scan_enable_out(scan_enable_out),
  .safety_switching_output_out(safety_switching_output_out), .ind_out(ind_out),
  .state_out(state_out));

// >>> testbench/tb_light_curtain_output_control.sv
// Self-checking testbench of the light curtain output control.
`timescale 1ns/10ps
module tb_light_curtain_output_control;
  import lcoc_pkg::*;
  logic mclk_in = 0, nrst_in = 0, done = 0, sfault = 0, latch = 0, fault = 0, press = 0;
  logic busy, sw, scan_en;
  logic [7:0] len = 8'h00, z;
  logic [1:0] outs;
  lcoc_scan_s scan = '0;
  lcoc_ind_s ind;
  lcoc_state_e st;
  int miscompares = 0, comparisons = 0, seed = 20, n;
  localparam lcoc_scan_s CLR = lcoc_scan_s'(11'h400);
  lcoc_output_ctrl #(.DEB_CYC(4), .MIN_CYC(20), .MAX_CYC(60), .HALF_CYC(4)) DUT (
    .mclk_in(mclk_in), .nrst_in(nrst_in), .selftest_done_in(done),
    .selftest_fault_in(sfault), .latch_mode_in(latch), .fault_in(fault), .scan_in(scan),
    .reset_switch_in(sw), .scan_enable_out(scan_en), .safety_switching_output_out(outs),
    .ind_out(ind), .state_out(st));
  lcoc_operator u_op (.mclk_in(mclk_in), .press_in(press), .len_in(len), .busy_out(busy),
    .switch_out(sw));
  // ----------------------------------------------------------------
  // Clock, watchdog and helpers.
  // ----------------------------------------------------------------
  initial forever #50 mclk_in = ~mclk_in;
  // The tests need under 500 cycles, so 30000 cycles means a hang.
  initial begin
    #3000000;
    miscompares++;
    wrap_up();
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected at %0t: saw %0h, wanted %0h", $time, seen, exp);
    end
  endtask : chk
  task automatic cyc(input int k);
    repeat (k) @(posedge mclk_in);
  endtask : cyc
  // Waits a bounded span for a state, then checks it and the modelled outputs.
  task automatic wait_st(input lcoc_state_e s, input int lim);
    @(negedge mclk_in);
    for (int i = 1; i < lim && st !== s; i++) @(negedge mclk_in);
    chk(st, s);
    chk(outs, (s == ST_RUN) ? 2'h3 : 2'h0);
    @(posedge mclk_in);
  endtask : wait_st
  task automatic push(input int k);
    press <= 1'b1;
    len <= k[7:0];
    cyc(1);
    press <= 1'b0;
    cyc(1);
    for (int i = 0; i < 300 && busy; i++) cyc(1);
    cyc(12);
  endtask : push
  task automatic flashes(input int exp);
    cyc(2);
    n = 0;
    repeat (32) begin
      @(negedge mclk_in);
      n += ind.reset_led;
    end
    chk(n, exp);
    @(posedge mclk_in);
  endtask : flashes
  task automatic power(input logic lm, input logic sf);
    nrst_in <= 1'b0;
    latch <= lm;
    sfault <= sf;
    scan <= '0;
    cyc(16);
    nrst_in <= 1'b1;
    cyc(2);
    done <= 1'b1;
    cyc(1);
    done <= 1'b0;
  endtask : power
  task automatic wrap_up();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : wrap_up
  // ----------------------------------------------------------------
  // Tests.
  // ----------------------------------------------------------------
  initial begin
    power(1'b0, 1'b0);
    wait_st(ST_ALIGN, 8);
    chk(scan_en, 1'b1);
    scan <= CLR;
    wait_st(ST_RUN, 2);
    for (int i = 0; i < 4; i++) begin
      z = $random(seed);
      scan <= lcoc_scan_s'({3'h5, z | 8'h02});
      wait_st(ST_LATCHED, 2);
      scan <= CLR;
      wait_st(ST_RUN, 2);
    end
    scan <= lcoc_scan_s'(11'h701);
    wait_st(ST_LATCHED, 2);
    chk({ind.zone_green, ind.zone_red}, 16'h0001);
    fault <= 1'b1;
    wait_st(ST_LOCKOUT, 2);
    chk(ind.diag_fault, 1'b1);
    fault <= 1'b0;
    scan <= CLR;
    cyc(20);
    wait_st(ST_LOCKOUT, 1);
    $display("test auto restart and lockout done");
    power(1'b1, 1'b0);
    wait_st(ST_ALIGN, 8);
    scan <= CLR;
    wait_st(ST_WAIT_RESET, 2);
    flashes(8);
    push(10);
    wait_st(ST_WAIT_RESET, 1);
    push(70);
    wait_st(ST_WAIT_RESET, 1);
    push(25 + ($random(seed) & 15));
    wait_st(ST_RUN, 4);
    scan <= lcoc_scan_s'(11'h580);
    wait_st(ST_LATCHED, 2);
    push(30);
    wait_st(ST_LATCHED, 1);
    scan <= CLR;
    flashes(16);
    chk(ind.zone_green, 8'hFF);
    wait_st(ST_LATCHED, 1);
    push(40);
    wait_st(ST_RUN, 4);
    $display("test latching restart done");
    power(1'b0, 1'b1);
    wait_st(ST_LOCKOUT, 8);
    chk({scan_en, ind.diag_fault}, 2'h1);
    $display("test power-up fault done");
    wrap_up();
  end
endmodule : tb_light_curtain_output_control
